// ===== test/cpu_bus_model.sv
// cpu-side register master for the timer block
// assumes single-cycle strobes, driven 1 ns after the rising edge
`timescale 1ns/1ps
module cpu_bus_model (
    input wire logic ref_clk,
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [31:0] regWdata,
    input wire logic [31:0] regRdata
);
    initial
    begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 32'h0000_0000;
    end
    // load writes and clear-bit writes go through here
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge ref_clk);
        #1;
        regWrite = 1'b0;
        // stale data is scrambled so nothing leans on it
        regWdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge ref_clk);
        #1;
        regRead = 1'b0;
        regAddr = ~a;
        d = regRdata;
    endtask
endmodule

// ===== test/timer_and_pci_irq_control_tb.sv
// self-checking bench for timer_irq_ctrl
// assumes the cpu_bus_model master and timer_irq_map.svh offsets
`timescale 1ns/1ps
`include "timer_irq_map.svh"
module timer_and_pci_irq_control_tb;
    logic ref_clk, rst_n, regWrite, regRead, pciIntA_n, pciSerr_n, cpuIrq, nmi_n;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, v, c0, seed;
    int failures = 0;
    int n_compared = 0;
    timer_irq_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .pciIntA_n(pciIntA_n), .pciSerr_n(pciSerr_n),
        .cpuIrq(cpuIrq), .nmi_n(nmi_n));
    cpu_bus_model host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // bounded wait on cpuIrq high or nmi_n low
    task automatic await(input bit nmi);
        int i;
        for (i = 0; i < 100 && (nmi ? nmi_n !== 1'b0 : cpuIrq !== 1'b1); i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        if (i == 100)
        begin
            failures++;
            $display("wrong value at %0t: interrupt never came", $time);
            test_done();
        end
    endtask
    task automatic go_reset();
        @(posedge ref_clk);
        #1;
        rst_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
    endtask
    initial
    begin
        rst_n = 1'b0;
        pciIntA_n = 1'b1;
        pciSerr_n = 1'b1;
        seed = 32'h0000_005a;
        go_reset();
        host.rd(`CTRL_OFF, v);
        check(v, 32'h0000_0000);
        check({cpuIrq, nmi_n}, 32'h1);
        for (int k = 0; k < 8; k++)
        begin
            seed = xs(seed);
            v = (k == 0) ? 32'hffff_ffff : seed;
            host.wr(`CTRL_OFF, v);
            host.rd(`CTRL_OFF, c0);
            check(c0, v & `CTRL_RW_MASK);
        end
        host.wr(8'h40, seed);
        host.rd(8'h40, v);
        check(v, 32'h0);
        $display("register test done");
        for (int d = 0; d < 4; d++)
        begin
            host.wr(8'hf0, 32'h0);
            host.wr(`CTRL_OFF, 32'h4 | (d << 28));
            host.rd(8'hfc, c0);
            repeat (64) @(posedge ref_clk);
            host.rd(8'hfc, v);
            check({31'h0, (v - c0 + 32'h1 - (32'h42 >> d)) <= 32'h2}, 32'h1);
        end
        host.wr(`CTRL_OFF, 32'h0);
        host.rd(8'hfc, c0);
        repeat (20) @(posedge ref_clk);
        host.rd(8'hfc, v);
        check(v, c0);
        $display("divider test done");
        host.wr(8'hec, 32'hffff_fffc);
        host.wr(`CTRL_OFF, 32'h2002);
        await(1'b0);
        host.rd(`CTRL_OFF, v);
        check(v & 32'h700, 32'h200);
        host.rd(`CTRL_OFF, v);
        check(v & 32'h700, 32'h0);
        host.rd(8'hf8, v);
        check(v, 32'hffff_ffff);
        host.rd(8'hec, v);
        check(v, 32'hffff_fffc);
        check({31'h0, cpuIrq}, 32'h0);
        host.wr(8'hec, 32'hffff_fffc);
        host.wr(`CTRL_OFF, 32'h0002_2002);
        await(1'b0);
        host.rd(`CTRL_OFF, v);
        repeat (8) @(posedge ref_clk);
        host.rd(`CTRL_OFF, v);
        check(v & 32'h200, 32'h200);
        // reloading timer keeps firing with its enable off; irq must stay quiet
        host.wr(`CTRL_OFF, 32'h0002_0002);
        repeat (8) @(posedge ref_clk);
        #1;
        check({31'h0, cpuIrq}, 32'h0);
        host.rd(`CTRL_OFF, v);
        check(v & 32'h200, 32'h200);
        // stop it and drain the pending flag before the watchdog case
        host.wr(`CTRL_OFF, 32'h0);
        host.rd(`CTRL_OFF, v);
        $display("timer test done");
        host.wr(8'he8, 32'hffff_fffe);
        host.wr(`CTRL_OFF, 32'h1001);
        await(1'b1);
        host.rd(`CTRL_OFF, v);
        check(v & 32'h700, 32'h100);
        repeat (3) @(posedge ref_clk);
        #1;
        check({31'h0, nmi_n}, 32'h1);
        host.wr(`CTRL_OFF, 32'h0);
        pciSerr_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check({31'h0, nmi_n}, 32'h0);
        pciSerr_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        check({31'h0, nmi_n}, 32'h1);
        $display("nmi test done");
        pciIntA_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        pciIntA_n = 1'b1;
        host.rd(`CTRL_OFF, v);
        check(v & 32'h20, 32'h20);
        check({31'h0, cpuIrq}, 32'h0);
        host.wr(`CTRL_OFF, 32'h8);
        repeat (2) @(posedge ref_clk);
        #1;
        check({31'h0, cpuIrq}, 32'h1);
        host.wr(`CTRL_OFF, 32'h8);
        host.rd(`CTRL_OFF, v);
        check(v & 32'h20, 32'h20);
        host.wr(`CTRL_OFF, 32'h18);
        host.rd(`CTRL_OFF, v);
        check(v & 32'h20, 32'h0);
        check({31'h0, cpuIrq}, 32'h0);
        $display("inta test done");
        host.wr(`CTRL_OFF, 32'h3f07_700f);
        go_reset();
        host.rd(`CTRL_OFF, v);
        check(v, 32'h0);
        check({cpuIrq, nmi_n}, 32'h1);
        $display("reset test done");
        test_done();
    end
endmodule

// ===== verilog/timer_irq_ctrl.sv
// three up-counting timers, their shared control/status register,
// latched pci inta# and the nmi output
// assumes a single-cycle cpu register port in the ref_clk domain and
// pci inta#/serr# already synchronous to ref_clk
`timescale 1ns/1ps
`include "timer_irq_map.svh"

module timer_irq_ctrl #(
    parameter int NUM_TIMERS = 3,
    parameter int COUNT_W = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    input wire logic pciIntA_n,
    input wire logic pciSerr_n,
    output logic cpuIrq,
    output logic nmi_n
);

    logic [31:0] ctrl_reg;
    logic [NUM_TIMERS-1:0] timerPend_reg;
    logic [NUM_TIMERS-1:0] timerPend_next;
    logic pciPend_reg;
    logic pciPend_next;
    logic [2:0] prescale_reg;
    logic [COUNT_W-1:0] load_reg [NUM_TIMERS];
    logic [COUNT_W-1:0] count_reg [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] expired_reg;
    logic [NUM_TIMERS-1:0] tick;
    logic [NUM_TIMERS-1:0] termEvent;
    logic [NUM_TIMERS-1:0] loadWrite;
    logic [NUM_TIMERS-1:0] runBits;
    logic [NUM_TIMERS-1:0] irqEnBits;
    logic [NUM_TIMERS-1:0] reloadBits;
    logic ctrlRead;
    logic ctrlWrite;
    logic [31:0] ctrlView;
    logic [31:0] readMux;
    logic cpuIrq_reg;
    logic nmi_n_reg;
    logic [31:0] regRdata_reg;

    // one prescaler shared by all timers; a timer ticks when the low bits wrap
    function automatic logic tickFor(input logic [1:0] sel, input logic [2:0] pre);
        case (timer_irq_pkg::clk_div_e'(sel))
            timer_irq_pkg::DIV_BY_1: tickFor = 1'b1;
            timer_irq_pkg::DIV_BY_2: tickFor = pre[0];
            timer_irq_pkg::DIV_BY_4: tickFor = &pre[1:0];
            default: tickFor = &pre;
        endcase
    endfunction

    function automatic logic [7:0] slotAddr(input logic [7:0] base, input int idx);
        slotAddr = base + 8'(idx * 4);
    endfunction

    assign ctrlRead = regRead && (regAddr == `CTRL_OFF);
    assign ctrlWrite = regWrite && (regAddr == `CTRL_OFF);

    always_comb
    begin
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
            runBits[i] = ctrl_reg[`RUN_POS + i];
            irqEnBits[i] = ctrl_reg[`IRQ_EN_POS + i];
            reloadBits[i] = ctrl_reg[`RELOAD_POS + i];
            tick[i] = tickFor(ctrl_reg[`DIV_POS + 2 * i +: 2], prescale_reg);
            loadWrite[i] = regWrite && (regAddr == slotAddr(`LOAD_BASE, i));
            termEvent[i] = runBits[i] && !expired_reg[i] && tick[i] && (&count_reg[i]);
        end
    end

    // rst_n is the pci bus reset, sampled by ref_clk; state leaves reset on the first rising ref_clk edge with rst_n high
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            prescale_reg <= 3'h0;
        else
            prescale_reg <= prescale_reg + 3'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ctrl_reg <= `CTRL_RESET;
        else if (ctrlWrite)
            ctrl_reg <= regWdata & `CTRL_RW_MASK;
    end

    // load, count and expiry per timer; a write restarts from the new value
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                load_reg[i] <= '0;
                count_reg[i] <= '0;
            end
            expired_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                if (loadWrite[i])
                begin
                    load_reg[i] <= regWdata[COUNT_W-1:0];
                    count_reg[i] <= regWdata[COUNT_W-1:0];
                    expired_reg[i] <= 1'b0;
                end
                else if (termEvent[i])
                begin
                    // without reload the timer parks at all ones until reloaded
                    if (reloadBits[i])
                        count_reg[i] <= load_reg[i];
                    else
                        expired_reg[i] <= 1'b1;
                end
                else if (runBits[i] && tick[i] && !expired_reg[i])
                    count_reg[i] <= count_reg[i] + 1'b1;
            end
        end
    end

    // set beats the read clear, so an event on the reading edge survives
    always_comb
    begin
        timerPend_next = termEvent
            | (timerPend_reg & ~{NUM_TIMERS{ctrlRead}});
        pciPend_next = !pciIntA_n
            || (pciPend_reg && !(ctrlWrite && regWdata[`PCI_CLEAR_POS]));
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            timerPend_reg <= '0;
            pciPend_reg <= 1'b0;
        end
        else
        begin
            timerPend_reg <= timerPend_next;
            pciPend_reg <= pciPend_next;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cpuIrq_reg <= 1'b0;
            nmi_n_reg <= 1'b1;
        end
        else
        begin
            cpuIrq_reg <= (|(timerPend_reg & irqEnBits))
                || (pciPend_reg && ctrl_reg[`PCI_GATE_POS]);
            nmi_n_reg <= !(!pciSerr_n || (timerPend_reg[0] && irqEnBits[0]));
        end
    end

    always_comb
    begin
        ctrlView = ctrl_reg;
        ctrlView[`PCI_PEND_POS] = pciPend_reg;
        ctrlView[`PEND_POS +: NUM_TIMERS] = timerPend_reg;
        readMux = 32'h0000_0000;
        if (regAddr == `CTRL_OFF)
            readMux = ctrlView;
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
            if (regAddr == slotAddr(`LOAD_BASE, i))
                readMux = 32'(load_reg[i]);
            if (regAddr == slotAddr(`COUNT_BASE, i))
                readMux = 32'(count_reg[i]);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            regRdata_reg <= 32'h0000_0000;
        else if (regRead)
            regRdata_reg <= readMux;
    end

    assign regRdata = regRdata_reg;
    assign cpuIrq = cpuIrq_reg;
    assign nmi_n = nmi_n_reg;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence ctrlReadSeq;
        regRead && (regAddr == `CTRL_OFF);
    endsequence

    sequence pciClearSeq;
        regWrite && (regAddr == `CTRL_OFF) && regWdata[`PCI_CLEAR_POS] && pciIntA_n;
    endsequence

    sequence noIrqCause;
        (timerPend_reg & irqEnBits) == '0 && !(pciPend_reg && ctrl_reg[`PCI_GATE_POS]);
    endsequence

    // watchdog event: pending one edge later, nmi output one edge after that
    sequence wdogEventSeq;
        termEvent[0] && irqEnBits[0] && !ctrlWrite;
    endsequence

    sequence wdogNmiSeq;
        timerPend_reg[0] ##1 !nmi_n;
    endsequence

    chk_reset_zero: assert property ($past(!rst_n) |-> ctrl_reg == 32'h0
        && timerPend_reg == '0)
        else $error("control state not zero after reset");

    chk_event_sets_pend: assert property (termEvent[1]
        |=> timerPend_reg[1] ##1 (timerPend_reg[1] || $past(ctrlRead)))
        else $error("terminal count did not set pending");

    chk_set_beats_clear: assert property (ctrlReadSeq and termEvent[0]
        |=> timerPend_reg[0])
        else $error("pending lost when event met read clear");

    chk_read_clears_pend: assert property (ctrlReadSeq and (termEvent == '0)
        |=> timerPend_reg == '0)
        else $error("register read did not clear pending flags");

    chk_pci_clear: assert property (pciClearSeq |=> !pciPend_reg)
        else $error("inta pending not cleared by write");

    chk_pci_latch: assert property (!pciIntA_n |=> pciPend_reg)
        else $error("inta assertion not latched");

    chk_irq_quiet: assert property (noIrqCause |=> !cpuIrq)
        else $error("cpu irq without enabled cause");

    chk_serr_nmi: assert property (!pciSerr_n |=> !nmi_n)
        else $error("serr did not raise nmi");

    chk_wdog_nmi: assert property (wdogEventSeq |=> wdogNmiSeq)
        else $error("watchdog terminal count did not raise nmi");

    chk_reload_value: assert property (termEvent[2] && reloadBits[2]
        && !loadWrite[2] |=> count_reg[2] == $past(load_reg[2]))
        else $error("timer did not reload start value");

    chk_count_step: assert property (runBits[1] && tick[1] && !expired_reg[1]
        && !(&count_reg[1]) && !loadWrite[1]
        |=> count_reg[1] == $past(count_reg[1]) + 1'b1)
        else $error("timer did not count up by one");

    chk_reserved_zero: assert property (ctrlReadSeq
        |=> (regRdata & ~32'h3f07_772f) == 32'h0)
        else $error("reserved bits read nonzero");

    chk_pend_view: assert property (ctrlReadSeq
        |=> regRdata[`PEND_POS +: NUM_TIMERS] == $past(timerPend_reg))
        else $error("timer pending flags not shown on read");

    chk_pci_view: assert property (ctrlReadSeq
        |=> regRdata[`PCI_PEND_POS] == $past(pciPend_reg))
        else $error("inta pending not shown on read");

    chk_pci_gate: assert property (pciPend_reg && ctrl_reg[`PCI_GATE_POS]
        |=> cpuIrq)
        else $error("gated inta did not reach cpu irq");

    chk_pend_hold: assert property (timerPend_reg[2] && !ctrlRead
        |=> timerPend_reg[2])
        else $error("pending flag dropped without read");

    chk_stop_holds: assert property (!runBits[2] && !loadWrite[2]
        |=> count_reg[2] == $past(count_reg[2]))
        else $error("stopped timer changed its count");

    chk_load_start: assert property (loadWrite[0]
        |=> count_reg[0] == $past(regWdata[COUNT_W-1:0])
            && load_reg[0] == $past(regWdata[COUNT_W-1:0]))
        else $error("load write did not set start value");

    chk_count_read: assert property (regRead && regAddr == `COUNT_BASE + 8'h04
        |=> regRdata == $past(count_reg[1]) && $stable(load_reg[1]))
        else $error("count read wrong or disturbed load value");

    chk_slow_tick: assert property (ctrl_reg[`DIV_POS +: 2] == 2'h3 && tick[0]
        |-> prescale_reg == 3'h7)
        else $error("divide by eight ticked off its phase");

    chk_irq_raise: assert property ((timerPend_reg & irqEnBits) != '0
        |=> cpuIrq)
        else $error("enabled timer pending did not raise cpu irq");

endmodule

// ===== verilog/timer_irq_map.svh
// register map, field positions and reset values of the timer/interrupt block
// assumes byte addresses on an 8-bit register offset, one 32-bit word per register
`ifndef TIMER_IRQ_MAP_SVH
`define TIMER_IRQ_MAP_SVH

`define CTRL_OFF 8'he4
`define LOAD_BASE 8'he8
`define COUNT_BASE 8'hf4

`define CTRL_RESET 32'h0000_0000
`define CTRL_RW_MASK 32'h3f07_700f

`define RUN_POS 0
`define PCI_GATE_POS 3
`define PCI_CLEAR_POS 4
`define PCI_PEND_POS 5
`define PEND_POS 8
`define IRQ_EN_POS 12
`define RELOAD_POS 16
`define DIV_POS 24

`endif

// ===== verilog/timer_irq_pkg.sv
// types shared by the timer/interrupt block
// assumes the constants of timer_irq_map.svh sit beside it
package timer_irq_pkg;

    typedef logic [31:0] word_t;

    typedef enum logic [1:0] {
        DIV_BY_1 = 2'h0,
        DIV_BY_2 = 2'h1,
        DIV_BY_4 = 2'h2,
        DIV_BY_8 = 2'h3
    } clk_div_e;

endpackage
